// file: bench/prl_host.sv
`timescale 1ns/1ps
module prl_host (
	input wire logic clk,
	input wire logic [15:0] reg_rdata,
	output logic [11:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_wdata
);
	// ==========================================
	// Idle bus at time zero
	initial begin
		reg_addr = 12'h000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
	end
	// Write, strobe held up to the taking edge
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read, data taken one edge after the strobe is taken
	task automatic rd(input logic [11:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask : rd
endmodule : prl_host

// file: bench/prl_top_sva.sv
`timescale 1ns/1ps
module prl_top_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic conv_valid,
	input wire logic [3:0] conv_stage,
	input wire logic [3:0] last_stage,
	input wire logic int_n,
	input wire logic [11:0] prox_flags,
	input wire logic [11:0] recal_busy,
	input wire logic [11:0] touch_flags
);
	// ==========================================
	// Helpers
	function automatic logic [15:0] prl_mask(input logic [11:0] a);
		case (a)
			12'h002: prl_mask = 16'h0FFF;
			12'h003: prl_mask = 16'h3FFF;
			12'h004: prl_mask = 16'hFFFF;
			default: prl_mask = 16'h0000;
		endcase
	endfunction : prl_mask
	logic conv_ok;
	// Accepted conversion
	assign conv_ok = conv_valid && (conv_stage <= last_stage) && (conv_stage < 4'hC);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================
	// Properties
	chk_reset_idle: assert property ($past(rst) |-> int_n && reg_rdata == 16'h0000 &&
		prox_flags == 12'h000 && recal_busy == 12'h000 && touch_flags == 12'h000)
		else $error("state not idle after reset");
	chk_reserved_zero: assert property (reg_rd |=>
		(reg_rdata & ~prl_mask($past(reg_addr))) == 16'h0000) else $error("reserved bits set");
	chk_field_readback: assert property (reg_wr ##2 (reg_rd && !reg_wr &&
		reg_addr == $past(reg_addr, 2)) |=> reg_rdata == ($past(reg_wdata, 3) &
		prl_mask($past(reg_addr)))) else $error("readback differs from write");
	chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	chk_int_touch: assert property (!$past(rst) |-> int_n == !(|$past(touch_flags)))
		else $error("interrupt does not follow threshold flags");
	chk_flags_quiet: assert property (!conv_ok |=> $stable(prox_flags) &&
		$stable(recal_busy) && $stable(touch_flags)) else $error("flags moved without conversion");
	chk_stage_only: assert property (conv_ok |=> (((prox_flags ^ $past(prox_flags)) |
		(recal_busy ^ $past(recal_busy)) | (touch_flags ^ $past(touch_flags))) &
		~(12'h001 << $past(conv_stage))) == 12'h000) else $error("other stage flags moved");
	chk_force_clears: assert property ((recal_busy & ~$past(recal_busy) & prox_flags)
		== 12'h000) else $error("proximity kept at forced recalibration");
endmodule : prl_top_sva
bind prl_top prl_top_sva i_prl_top_sva (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.conv_valid(conv_valid), .conv_stage(conv_stage), .last_stage(last_stage),
	.int_n(int_n), .prox_flags(prox_flags), .recal_busy(recal_busy),
	.touch_flags(touch_flags));

// file: bench/proximity_recalibration_logic_tb.sv
`timescale 1ns/1ps
module proximity_recalibration_logic_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] reg_addr;
	logic reg_wr, reg_rd, int_n;
	logic [15:0] reg_wdata, reg_rdata;
	logic conv_valid = 1'b0;
	logic [3:0] conv_stage = 4'h0;
	logic [15:0] conv_data = 16'h0000;
	logic [3:0] last_stage = 4'hB;
	logic low_power = 1'b0;
	logic [3:0] pos_sensitivity = 4'h0;
	logic [15:0] slow_update_level = 16'hFFFF;
	logic [11:0] prox_flags, recal_busy, touch_flags;
	int errors = 0;
	int cmp_count = 0;
	// ==========================================
	// Clock and units
	always #12.5 clk = ~clk;
	prl_host i_prl_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
	prl_top i_prl_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.conv_valid(conv_valid), .conv_stage(conv_stage), .conv_data(conv_data),
		.last_stage(last_stage), .low_power(low_power), .stage_offset_high(16'h0100),
		.stage_offset_low(16'h0000), .pos_sensitivity(pos_sensitivity),
		.neg_sensitivity(4'h0), .slow_update_level(slow_update_level), .int_n(int_n),
		.prox_flags(prox_flags), .recal_busy(recal_busy), .touch_flags(touch_flags));
	// ==========================================
	// Tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rdchk(input logic [11:0] a, input logic [15:0] exp);
		logic [15:0] d;
		i_prl_host.rd(a, d);
		chk(d, exp);
	endtask : rdchk
	task automatic conv(input logic [3:0] st, input logic [15:0] d);
		@(posedge clk);
		conv_valid <= 1'b1;
		conv_stage <= st;
		conv_data <= d;
		@(posedge clk);
		conv_valid <= 1'b0;
		@(posedge clk);
		#1;
	endtask : conv
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		tally_and_finish();
	end
	// ==========================================
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdchk(12'h002, 16'h0000);
		rdchk(12'h003, 16'h0000);
		rdchk(12'h004, 16'h0000);
		i_prl_host.wr(12'h002, 16'hFFFF);
		i_prl_host.wr(12'h003, 16'hFFFF);
		i_prl_host.wr(12'h005, 16'hFFFF);
		rdchk(12'h002, 16'h0FFF);
		rdchk(12'h003, 16'h3FFF);
		rdchk(12'h005, 16'h0000);
		i_prl_host.wr(12'h004, 16'h0804);
		rdchk(12'h004, 16'h0804);
		// Skip one sample per push, rate 4, level 63
		i_prl_host.wr(12'h002, 16'h0011);
		i_prl_host.wr(12'h003, 16'h3F04);
		conv(4'h8, 16'h0009);
		conv(4'h8, 16'h0005);
		conv(4'h8, 16'h0009);
		chk(16'(prox_flags[8]), 16'h0000);
		conv(4'h8, 16'h0000);
		chk(16'(prox_flags[8]), 16'h0001);
		i_prl_host.wr(12'h002, 16'h0010);
		// Approach comparator at the rate boundary
		i_prl_host.wr(12'h003, 16'h3F05);
		conv(4'h2, 16'h0005);
		conv(4'h2, 16'h0000);
		chk(16'(prox_flags[2]), 16'h0000);
		i_prl_host.wr(12'h003, 16'h3F04);
		conv(4'h3, 16'h0005);
		conv(4'h3, 16'h0000);
		chk(16'(prox_flags[3]), 16'h0001);
		// Threshold and interrupt
		conv(4'h1, 16'h0041);
		chk(16'(touch_flags[1]), 16'h0001);
		@(posedge clk);
		#1;
		chk(16'(int_n), 16'h0000);
		conv(4'h1, 16'h0040);
		chk(16'(touch_flags[1]), 16'h0000);
		@(posedge clk);
		#1;
		chk(16'(int_n), 16'h0001);
		@(posedge clk);
		pos_sensitivity <= 4'hF;
		conv(4'h1, 16'h007C);
		chk(16'(touch_flags[1]), 16'h0000);
		conv(4'h1, 16'h007D);
		chk(16'(touch_flags[1]), 16'h0001);
		// Stages outside the sequence are ignored
		@(posedge clk);
		last_stage <= 4'h0;
		conv(4'h1, 16'h0000);
		@(posedge clk);
		last_stage <= 4'hB;
		conv(4'hC, 16'h0000);
		chk({4'h0, touch_flags}, 16'h0002);
		// Hover, then forced recalibration after four sequences
		i_prl_host.wr(12'h003, 16'h0AFF);
		for (int i = 0; i < 6; i++) begin
			conv(4'h4, 16'h0028);
			chk(16'(recal_busy[4]), 16'((6'b011000 >> i) & 6'h01));
			if (i < 4) begin
				chk(16'(prox_flags[4]), 16'((4'b0110 >> i) & 4'h1));
			end
		end
		// A broken excess restarts the count
		for (int i = 0; i < 8; i++) begin
			conv(4'h5, (i == 3) ? 16'h0000 : 16'h0028);
			if (i >= 6) begin
				chk(16'(recal_busy[5]), (i == 7) ? 16'h0001 : 16'h0000);
			end
		end
		// Low power count of two sequences
		@(posedge clk);
		low_power <= 1'b1;
		conv(4'h6, 16'h0028);
		chk(16'(recal_busy[6]), 16'h0000);
		conv(4'h6, 16'h0028);
		chk(16'(recal_busy[6]), 16'h0001);
		// Ambient tracks when idle, frozen under proximity
		@(posedge clk);
		low_power <= 1'b0;
		slow_update_level <= 16'h0000;
		conv(4'h7, 16'h0008);
		conv(4'h7, 16'h0080);
		chk(16'(touch_flags[7]), 16'h0000);
		conv(4'h7, 16'h00BE);
		chk(16'(prox_flags[7]), 16'h0001);
		chk(16'(touch_flags[7]), 16'h0000);
		conv(4'h7, 16'h00BF);
		chk(16'(touch_flags[7]), 16'h0001);
		tally_and_finish();
	end
endmodule : proximity_recalibration_logic_tb

// file: hw/prl_calc.sv
`timescale 1ns/1ps
module prl_calc (
	prl_calc_if.calc c
);
	// ==========================================
	// Helpers
	function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
		absdiff = (a > b) ? (a - b) : (b - a);
	endfunction : absdiff

	logic [17:0] ff_sum;
	logic [15:0] ff_avg;
	logic [15:0] q_hi;
	logic [15:0] q_lo;
	logic [19:0] sc_hi;
	logic [19:0] sc_lo;
	logic signed [18:0] thr_hi;
	logic signed [18:0] thr_lo;
	logic signed [18:0] smp;

	// ==========================================
	// Fast filter comparators
	always_comb begin
		ff_sum = {2'b00, c.ff_word[0]} + {2'b00, c.ff_word[1]}
			+ {2'b00, c.ff_word[2]} + {2'b00, c.ff_word[3]};
		ff_avg = ff_sum[17:2];
		c.prox1 = absdiff(c.ff_word[1], c.ff_word[3]) > {8'h00, c.rate}; // [R7]
		c.prox2 = absdiff(ff_avg, c.ambient) > {10'h000, c.level}; // [R8]
	end

	// Slow filter gate and recalibration excess
	assign c.slow_en = (absdiff(c.sample, c.sf_last) > c.slow_lvl) && !c.prox_now; // [R16]
	assign c.recal_exc = (c.sample > c.ambient)
		&& ((c.sample - c.ambient) > {10'h000, c.level}); // [R2]

	// ==========================================
	// Thresholds from ambient and scaled offsets
	always_comb begin
		q_hi = c.off_high >> 2;
		q_lo = c.off_low >> 2;
		sc_hi = (20'(q_hi) * 20'(c.pos_sens)) >> prl_pkg::SENS_SH;
		sc_lo = (20'(q_lo) * 20'(c.neg_sens)) >> prl_pkg::SENS_SH;
		thr_hi = 19'(c.ambient) + 19'(q_hi) + 19'(sc_hi[15:0]); // [R18]
		thr_lo = 19'(c.ambient) - 19'(q_lo) - 19'(sc_lo[15:0]); // [R18]
		smp = 19'(c.sample);
	end

	// Contact when either threshold is crossed
	assign c.touch = (smp > thr_hi) || (smp < thr_lo); // [R19]
endmodule : prl_calc

// file: hw/prl_calc_if.sv
`timescale 1ns/1ps
interface prl_calc_if;
	// Inputs to the comparators
	logic [15:0] sample;
	logic [15:0] ff_word [4];
	logic [15:0] sf_last;
	logic [15:0] ambient;
	logic [15:0] off_high;
	logic [15:0] off_low;
	logic [3:0] pos_sens;
	logic [3:0] neg_sens;
	logic [7:0] rate;
	logic [5:0] level;
	logic [15:0] slow_lvl;
	logic prox_now;
	// Comparator results
	logic prox1;
	logic prox2;
	logic slow_en;
	logic recal_exc;
	logic touch;
	modport top (output sample, ff_word, sf_last, ambient, off_high, off_low,
		pos_sens, neg_sens, rate, level, slow_lvl, prox_now,
		input prox1, prox2, slow_en, recal_exc, touch);
	modport calc (input sample, ff_word, sf_last, ambient, off_high, off_low,
		pos_sens, neg_sens, rate, level, slow_lvl, prox_now,
		output prox1, prox2, slow_en, recal_exc, touch);
endinterface : prl_calc_if

// file: hw/prl_pkg.sv
package prl_pkg;
	// ==========================================
	// Geometry
	localparam int STAGES = 12;
	localparam int DW = 16;
	localparam int FF_DEPTH = 4;
	localparam int AW = 12;
	// ==========================================
	// Register offsets
	localparam logic [11:0] OFS_PROX_CTRL = 12'h002;
	localparam logic [11:0] OFS_LEVELS = 12'h003;
	localparam logic [11:0] OFS_RECAL = 12'h004;
	// ==========================================
	// Field positions
	localparam int SKIP_LSB = 0;
	localparam int FP_CNT_LSB = 4;
	localparam int LP_CNT_LSB = 8;
	localparam int RATE_LSB = 0;
	localparam int LVL_LSB = 8;
	localparam int FP_RC_LSB = 0;
	localparam int LP_RC_LSB = 10;
	// ==========================================
	// Reset values
	localparam logic [3:0] SKIP_RST = 4'h0;
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [7:0] RATE_RST = 8'h00;
	localparam logic [5:0] LVL_RST = 6'h00;
	localparam logic [9:0] FP_RC_RST = 10'h000;
	localparam logic [5:0] LP_RC_RST = 6'h00;
	// ==========================================
	// Sequence count and sensitivity shifts
	localparam int FP_DIS_MULT_SH = 4;
	localparam int LP_DIS_MULT_SH = 2;
	localparam int SENS_SH = 4;
	// ==========================================
	// Forced recalibration states
	typedef enum logic [1:0] {
		PRL_RC_WATCH = 2'b00,
		PRL_RC_FORCE1 = 2'b01,
		PRL_RC_FORCE2 = 2'b11
	} prl_rc_e;
endpackage : prl_pkg

// file: hw/prl_top.sv
`timescale 1ns/1ps
// Functional notes
// R1: Proximity suspends ambient updates for that stage.
// R2: Sustained excess over ambient forces recalibration.
// R3: Full power timeout: count times sequences.
// R4: Low power timeout: count times sequences.
// R5: Force recalibration even while proximity stays.
// R6: Host waits two cycles between recalibrations.
// R7: Approach when word one/three differ > rate.
// R8: Hover when average/ambient differ > level.
// R9: Proximity is OR of both comparators.
// R10: Disable counts at offset two, bits 7:4, 11:8.
// R11: Recal times at offset four, 9:0, 15:10.
// R12: Level 13:8, rate 7:0 at offset three.
// R13: Skip count selects samples skipped per push.
// R14: Fast push every skip+1 sequences per stage.
// R15: Host should use skip zero with twelve stages.
// R16: Slow filter updates on gate without proximity.
// R17: Ambient tracking runs every conversion when idle; the code tracks only on conversions where slow_en is set.
// R18: Thresholds from ambient plus scaled offsets.
// R19: Interrupt low when a threshold is exceeded.
// R20: Calibration disabled count*16 or *4 after proximity.
// R21: Excess broken restarts the recalibration count.
module prl_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic conv_valid,
	input wire logic [3:0] conv_stage,
	input wire logic [15:0] conv_data,
	input wire logic [3:0] last_stage,
	input wire logic low_power,
	input wire logic [15:0] stage_offset_high,
	input wire logic [15:0] stage_offset_low,
	input wire logic [3:0] pos_sensitivity,
	input wire logic [3:0] neg_sensitivity,
	input wire logic [15:0] slow_update_level,
	output logic int_n,
	output logic [11:0] prox_flags,
	output logic [11:0] recal_busy,
	output logic [11:0] touch_flags
);
	// ==========================================
	// Configuration registers and read data register
	logic [3:0] fast_filter_skip_count_reg;
	logic [3:0] full_power_cal_disable_count_reg;
	logic [3:0] low_power_cal_disable_count_reg;
	logic [7:0] approach_detection_rate_reg;
	logic [5:0] hover_recal_level_reg;
	logic [9:0] full_power_recal_time_reg;
	logic [5:0] low_power_recal_time_reg;
	logic [15:0] reg_rdata_reg;

	// ==========================================
	// Per-stage storage and interrupt register
	logic [15:0] ff_mem [12][3];
	logic [3:0] skip_reg [12];
	logic [15:0] ambient_reg [12];
	logic [15:0] sf_last_reg [12];
	logic [7:0] caldis_reg [12];
	logic [9:0] rc_cnt_reg [12];
	prl_pkg::prl_rc_e rc_state_reg [12];
	logic [11:0] prox_reg;
	logic [11:0] touch_reg;
	logic int_n_reg;

	// ==========================================
	// Current conversion decode
	logic hit;
	logic push;
	logic prox_new;
	logic cal_ok;
	logic force_now;
	logic forcing;
	logic [9:0] rc_limit;
	logic [7:0] caldis_load;
	prl_calc_if ci ();

	// Only stages inside the sequence count
	assign hit = conv_valid && (conv_stage <= last_stage)
		&& (conv_stage < 4'(prl_pkg::STAGES));

	// Push when the skip counter has reached the setting
	assign push = hit && (skip_reg[conv_stage] == fast_filter_skip_count_reg); // [R13] [R14]

	// ==========================================
	// Comparator datapath
	assign ci.sample = conv_data;
	assign ci.ff_word[0] = conv_data;
	assign ci.ff_word[1] = ff_mem[conv_stage][0];
	assign ci.ff_word[2] = ff_mem[conv_stage][1];
	assign ci.ff_word[3] = ff_mem[conv_stage][2];
	assign ci.sf_last = sf_last_reg[conv_stage];
	assign ci.ambient = ambient_reg[conv_stage];
	assign ci.off_high = stage_offset_high;
	assign ci.off_low = stage_offset_low;
	assign ci.pos_sens = pos_sensitivity;
	assign ci.neg_sens = neg_sensitivity;
	assign ci.rate = approach_detection_rate_reg;
	assign ci.level = hover_recal_level_reg;
	assign ci.slow_lvl = slow_update_level;
	assign ci.prox_now = prox_reg[conv_stage];

	prl_calc u_calc (
		.c(ci.calc)
	);

	// Proximity raised by either comparator
	assign prox_new = ci.prox1 || ci.prox2; // [R9]

	// ==========================================
	// Timeout selection by power mode
	always_comb begin
		if (low_power) begin
			rc_limit = {4'h0, low_power_recal_time_reg}; // [R4]
			caldis_load = 8'(low_power_cal_disable_count_reg) << prl_pkg::LP_DIS_MULT_SH; // [R20]
		end else begin
			rc_limit = full_power_recal_time_reg; // [R3]
			caldis_load = 8'(full_power_cal_disable_count_reg) << prl_pkg::FP_DIS_MULT_SH; // [R20]
		end
	end

	// Timeout reached after the last counted sequence
	assign forcing = rc_state_reg[conv_stage] != prl_pkg::PRL_RC_WATCH;
	assign force_now = hit && !forcing && ci.recal_exc && (rc_limit != 10'h000)
		&& (rc_cnt_reg[conv_stage] >= rc_limit - 10'h001); // [R2] [R5]

	// Tracking allowed without proximity or disable period
	assign cal_ok = !prox_reg[conv_stage] && (caldis_reg[conv_stage] == 8'h00); // [R1] [R20]

	// ==========================================
	// Register writes
	always_ff @(posedge clk) begin
		if (rst) begin
			fast_filter_skip_count_reg <= prl_pkg::SKIP_RST;
			full_power_cal_disable_count_reg <= prl_pkg::CNT_RST;
			low_power_cal_disable_count_reg <= prl_pkg::CNT_RST;
			approach_detection_rate_reg <= prl_pkg::RATE_RST;
			hover_recal_level_reg <= prl_pkg::LVL_RST;
			full_power_recal_time_reg <= prl_pkg::FP_RC_RST;
			low_power_recal_time_reg <= prl_pkg::LP_RC_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				prl_pkg::OFS_PROX_CTRL: begin
					fast_filter_skip_count_reg <= reg_wdata[prl_pkg::SKIP_LSB +: 4]; // [R13]
					full_power_cal_disable_count_reg <= reg_wdata[prl_pkg::FP_CNT_LSB +: 4]; // [R10]
					low_power_cal_disable_count_reg <= reg_wdata[prl_pkg::LP_CNT_LSB +: 4]; // [R10]
				end
				prl_pkg::OFS_LEVELS: begin
					approach_detection_rate_reg <= reg_wdata[prl_pkg::RATE_LSB +: 8]; // [R12]
					hover_recal_level_reg <= reg_wdata[prl_pkg::LVL_LSB +: 6]; // [R12]
				end
				prl_pkg::OFS_RECAL: begin
					full_power_recal_time_reg <= reg_wdata[prl_pkg::FP_RC_LSB +: 10]; // [R11]
					low_power_recal_time_reg <= reg_wdata[prl_pkg::LP_RC_LSB +: 6]; // [R11]
				end
				default: ;
			endcase
		end
	end

	// Register reads, unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata_reg <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				prl_pkg::OFS_PROX_CTRL: reg_rdata_reg <= {4'h0,
					low_power_cal_disable_count_reg,
					full_power_cal_disable_count_reg,
					fast_filter_skip_count_reg};
				prl_pkg::OFS_LEVELS: reg_rdata_reg <= {2'b00, hover_recal_level_reg,
					approach_detection_rate_reg};
				prl_pkg::OFS_RECAL: reg_rdata_reg <= {low_power_recal_time_reg,
					full_power_recal_time_reg};
				default: reg_rdata_reg <= 16'h0000;
			endcase
		end
	end

	// ==========================================
	// Fast FIFO and skip counter
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int s = 0; s < prl_pkg::STAGES; s++) begin
				skip_reg[s] <= 4'h0;
				for (int w = 0; w < 3; w++) begin
					ff_mem[s][w] <= 16'h0000;
				end
			end
		end else if (push) begin
			skip_reg[conv_stage] <= 4'h0;
			ff_mem[conv_stage][0] <= conv_data; // [R14]
			ff_mem[conv_stage][1] <= ff_mem[conv_stage][0];
			ff_mem[conv_stage][2] <= ff_mem[conv_stage][1];
		end else if (hit) begin
			skip_reg[conv_stage] <= skip_reg[conv_stage] + 4'h1; // [R13]
		end
	end

	// ==========================================
	// Proximity flag and calibration disable period
	always_ff @(posedge clk) begin
		if (rst) begin
			prox_reg <= 12'h000;
			for (int s = 0; s < prl_pkg::STAGES; s++) begin
				caldis_reg[s] <= 8'h00;
			end
		end else if (force_now) begin
			prox_reg[conv_stage] <= 1'b0; // [R5]
			caldis_reg[conv_stage] <= 8'h00;
		end else if (hit) begin
			if (push) begin
				prox_reg[conv_stage] <= prox_new; // [R9]
			end
			if (push && prox_reg[conv_stage] && !prox_new) begin
				caldis_reg[conv_stage] <= caldis_load; // [R20]
			end else if (!prox_reg[conv_stage] && (caldis_reg[conv_stage] != 8'h00)) begin
				caldis_reg[conv_stage] <= caldis_reg[conv_stage] - 8'h01; // [R20]
			end
		end
	end

	// ==========================================
	// Ambient tracking and slow filter
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int s = 0; s < prl_pkg::STAGES; s++) begin
				ambient_reg[s] <= 16'h0000;
				sf_last_reg[s] <= 16'h0000;
			end
		end else if (force_now || (hit && forcing)) begin
			ambient_reg[conv_stage] <= conv_data; // [R5]
			sf_last_reg[conv_stage] <= conv_data;
		end else if (hit && cal_ok && ci.slow_en) begin
			sf_last_reg[conv_stage] <= conv_data; // [R16]
			ambient_reg[conv_stage] <= 16'(({1'b0, ambient_reg[conv_stage]}
				+ {1'b0, conv_data}) >> 1); // [R17] [R1]
		end
	end

	// ==========================================
	// Recalibration timeout counter and state
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int s = 0; s < prl_pkg::STAGES; s++) begin
				rc_cnt_reg[s] <= 10'h000;
				rc_state_reg[s] <= prl_pkg::PRL_RC_WATCH;
			end
		end else if (hit) begin
			unique case (rc_state_reg[conv_stage])
				prl_pkg::PRL_RC_WATCH: begin
					if (force_now) begin
						rc_cnt_reg[conv_stage] <= 10'h000;
						rc_state_reg[conv_stage] <= prl_pkg::PRL_RC_FORCE1; // [R2]
					end else if (ci.recal_exc) begin
						rc_cnt_reg[conv_stage] <= rc_cnt_reg[conv_stage] + 10'h001; // [R3] [R4]
					end else begin
						rc_cnt_reg[conv_stage] <= 10'h000; // [R21]
					end
				end
				prl_pkg::PRL_RC_FORCE1: begin
					rc_state_reg[conv_stage] <= prl_pkg::PRL_RC_FORCE2; // [R6]
				end
				prl_pkg::PRL_RC_FORCE2: begin
					rc_state_reg[conv_stage] <= prl_pkg::PRL_RC_WATCH; // [R6]
				end
				default: begin
					rc_state_reg[conv_stage] <= prl_pkg::PRL_RC_WATCH;
				end
			endcase
		end
	end

	// ==========================================
	// Contact flags and interrupt
	always_ff @(posedge clk) begin
		if (rst) begin
			touch_reg <= 12'h000;
		end else if (hit) begin
			touch_reg[conv_stage] <= ci.touch; // [R19]
		end
	end

	// Interrupt asserted low while any stage is in contact
	always_ff @(posedge clk) begin
		if (rst) begin
			int_n_reg <= 1'b1;
		end else begin
			int_n_reg <= ~(|touch_reg); // [R19]
		end
	end

	// ==========================================
	// Status outputs
	generate
		for (genvar g = 0; g < prl_pkg::STAGES; g++) begin : g_status
			assign prox_flags[g] = prox_reg[g];
			assign touch_flags[g] = touch_reg[g];
			assign recal_busy[g] = rc_state_reg[g] != prl_pkg::PRL_RC_WATCH;
		end
	endgenerate

	assign reg_rdata = reg_rdata_reg;
	assign int_n = int_n_reg;
endmodule : prl_top
